// File: core/csw_flag_bank.sv
// sticky clear-on-read flag bank
`timescale 1ns/10ps
`include "csw_regs.svh"
module csw_flag_bank (
  input logic i_clk,
  input logic i_rst_b,
  csw_flag_if.bank f
);
  import csw_pkg::*;

  // a set arriving with its clear wins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      f.q <= `CSW_WORD_RESET;
    end else begin
      f.q <= ((f.q & ~f.clr) | f.set) & `CSW_CLR_READ_MASK;
    end
  end
endmodule : csw_flag_bank

// File: core/csw_flag_if.sv
// set, clear and state of the sticky flag bank
`timescale 1ns/10ps
interface csw_flag_if;
  logic [31:0] set;
  logic [31:0] clr;
  logic [31:0] q;
  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface : csw_flag_if

// File: core/csw_pkg.sv
// types shared by the card status word design
package csw_pkg;
  typedef logic [31:0] csw_word_t;

  // card state codes carried in the status word
  typedef enum logic [3:0] {
    CSW_ST_IDLE = 4'h0,
    CSW_ST_READY = 4'h1,
    CSW_ST_IDENT = 4'h2,
    CSW_ST_STBY = 4'h3,
    CSW_ST_TRAN = 4'h4,
    CSW_ST_DATA = 4'h5,
    CSW_ST_RCV = 4'h6,
    CSW_ST_PRG = 4'h7,
    CSW_ST_DIS = 4'h8,
    CSW_ST_IO = 4'hF
  } csw_card_state_t;

  // response holding phase
  typedef enum logic [1:0] {
    CSW_PH_WAIT = 2'h1,
    CSW_PH_HOLD = 2'h2
  } csw_phase_t;
endpackage : csw_pkg

// File: core/csw_regs.svh
// bit positions, masks and frame layout of the card status word
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// status word layout
`define CSW_WORD_W 32
`define CSW_BIT_ARG_BOUNDS 31
`define CSW_BIT_ADDR_ALIGN 30
`define CSW_BIT_BLOCK_SIZE 29
`define CSW_BIT_WIPE_ORDER 28
`define CSW_BIT_WIPE_SELECT 27
`define CSW_BIT_PROT_WRITE 26
`define CSW_BIT_LOCKED 25
`define CSW_BIT_LOCK_FAIL 24
`define CSW_BIT_CMD_CHECK 23
`define CSW_BIT_DISALLOWED 22
`define CSW_BIT_ECC_FAIL 21
`define CSW_BIT_CTRL_FAULT 20
`define CSW_BIT_GENERAL 19
`define CSW_BIT_SPEC_REWRITE 16
`define CSW_BIT_WIPE_SKIP 15
`define CSW_BIT_ECC_BYPASS 14
`define CSW_BIT_WIPE_ABANDON 13
`define CSW_STATE_HI 12
`define CSW_STATE_LO 9

// bits cleared after being sent once
`define CSW_CLR_READ_MASK 32'hFD39_A000
// bits cleared one command after a valid reception
`define CSW_PREV_CMD_MASK 32'h00C0_0000
// reset value of the held word
`define CSW_WORD_RESET 32'h0000_0000

// normal response frame layout
`define CSW_FRAME_W 48
`define CSW_FRAME_START 47
`define CSW_FRAME_DIR 46
`define CSW_FRAME_IDX_HI 45
`define CSW_FRAME_IDX_LO 40
`define CSW_FRAME_STAT_HI 39
`define CSW_FRAME_STAT_LO 8
`define CSW_FRAME_CRC_HI 7
`define CSW_FRAME_CRC_LO 1
`define CSW_FRAME_END 0
`define CSW_FRAME_RESET 48'h0000_0000_0001

// link input bundle positions after synchronising
`define CSW_LNK_W 12
`define CSW_LNK_CLK 11
`define CSW_LNK_STROBE 10
`define CSW_LNK_CRC_OK 9
`define CSW_LNK_LEGAL 8
`define CSW_LNK_NORMAL 7
`define CSW_LNK_DONE 6
`define CSW_LNK_IDX_HI 5
`define CSW_LNK_IDX_LO 0

`endif

// File: core/csw_status_word.sv
// card status word: flag collection, snapshot and normal response frame
// Function
// - every normal response carries a 32-bit status word of held card status.
// - status word sits in response bits 39:8, after index, before crc.
// - by default each entry reports the command before the answered one.
// - unused and reserved bits, including 18 and 17, read zero.
// - execution faults latch while running; host reads them with a later command.
// - previous-command bits clear on valid reception, one command later.
// - bit 31 flags argument out of permitted range; clear on read.
// - bit 30 flags address misaligned to block length.
// - bit 29 flags illegal block length or byte count mismatch.
// - bit 28 erase order fault, bit 27 erase selection fault; clear on read.
// - bit 26 flags write to protected block or card; clear on read.
// - bit 25 follows the present locked condition.
// - bit 24 flags lock or unlock sequence or password fault.
// - bit 23 flags crc failure of previous command; previous-command clear.
// - bit 22 flags command illegal in state; previous-command clear.
// - bits 21, 20, 19 flag ecc, controller and general faults; clear on read.
// - bit 16 flags card-specific data rewrite mismatch or revert attempt.
// - bit 15 flags partial erase from protection or erase of protected card.
// - bit 14 follows whether execution bypassed internal ecc.
// - bit 13 flags erase sequence abandoned by outside command.
// - bits 12:9 hold state at reception; changes show next response.
// - state codes 0 idle through 8 disconnected, 15 io; 9-14 reserved.
`timescale 1ns/10ps
`include "csw_regs.svh"
module csw_status_word (
  input logic I_CORE_CLK,
  input logic I_RST_B,
  // link side, outside the core clock domain
  input logic I_CARD_CLK,
  input logic I_CMD_STROBE,
  input logic I_CMD_CRC_OK,
  input logic I_CMD_LEGAL,
  input logic I_CMD_NORMAL,
  input logic [5:0] I_CMD_INDEX,
  input logic I_RESP_DONE,
  // execution events from card logic, one-cycle pulses
  input logic I_ARGUMENT_BOUNDS_FAULT,
  input logic I_ADDR_ALIGN_FAULT,
  input logic I_BLOCK_SIZE_FAULT,
  input logic I_WIPE_ORDER_FAULT,
  input logic I_WIPE_SELECTION_FAULT,
  input logic I_PROTECTED_WRITE_ATTEMPT,
  input logic I_LOCK_PASSWORD_FAULT,
  input logic I_ECC_UNCORRECTABLE,
  input logic I_INTERNAL_CONTROLLER_FAULT,
  input logic I_GENERAL_FAULT,
  input logic I_SPEC_DATA_REWRITE_FAULT,
  input logic I_WIPE_SKIP,
  input logic I_WIPE_ABANDONED,
  // present card condition, levels
  input logic I_LOCKED_FLAG,
  input logic I_ECC_BYPASS,
  input csw_pkg::csw_card_state_t I_CARD_STATE,
  // outputs
  output logic [47:0] O_RESP_FRAME,
  output logic O_RESP_VALID,
  output logic [31:0] O_CARD_STATUS
);
  import csw_pkg::*;

  // clear-on-read part of a word, the only bits a sent response may clear
  function automatic csw_word_t csw_read_clear_bits(input csw_word_t word);
    return word & `CSW_CLR_READ_MASK;
  endfunction : csw_read_clear_bits

  // builds the status word from its three kinds of source
  function automatic csw_word_t csw_assemble(
    input csw_word_t sticky,
    input logic [1:0] prev,
    input logic locked,
    input logic bypass,
    input logic [3:0] state
  );
    csw_word_t w;
    w = `CSW_WORD_RESET;
    w = csw_read_clear_bits(sticky);
    w[`CSW_BIT_LOCKED] = locked;
    w[`CSW_BIT_ECC_BYPASS] = bypass;
    w[`CSW_BIT_CMD_CHECK] = prev[1];
    w[`CSW_BIT_DISALLOWED] = prev[0];
    w[`CSW_STATE_HI:`CSW_STATE_LO] = state;
    return w;
  endfunction : csw_assemble

  // normal response frame around a status word; crc field left for the serialiser
  function automatic logic [47:0] csw_frame(
    input logic [5:0] index,
    input csw_word_t word
  );
    logic [47:0] f;
    f = `CSW_FRAME_RESET;
    f[`CSW_FRAME_START] = 1'b0;
    f[`CSW_FRAME_DIR] = 1'b0;
    f[`CSW_FRAME_IDX_HI:`CSW_FRAME_IDX_LO] = index;
    f[`CSW_FRAME_STAT_HI:`CSW_FRAME_STAT_LO] = word;
    f[`CSW_FRAME_CRC_HI:`CSW_FRAME_CRC_LO] = 7'h00;
    f[`CSW_FRAME_END] = 1'b1;
    return f;
  endfunction : csw_frame

  // link inputs pass two flip-flops before use
  logic [11:0] link_sync1;
  logic [11:0] link_sync2;
  logic link_clk_d;
  logic link_rise;
  logic cmd_seen;
  logic cmd_crc_bad;
  logic cmd_illegal;
  logic cmd_taken;
  logic resp_sent;
  logic [5:0] link_index;

  // first stage: the only reader of the raw pins
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_sync1 <= 12'h000;
    end else begin
      link_sync1 <= {I_CARD_CLK, I_CMD_STROBE, I_CMD_CRC_OK, I_CMD_LEGAL,
                     I_CMD_NORMAL, I_RESP_DONE, I_CMD_INDEX};
    end
  end

  // second stage: all logic downstream reads only this one
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_sync2 <= 12'h000;
    end else begin
      link_sync2 <= link_sync1;
    end
  end

  // named views of the settled link bundle
  logic link_clk_s;
  logic link_strobe;
  logic link_crc_ok;
  logic link_legal;
  logic link_normal;
  logic link_done;

  assign link_clk_s = link_sync2[`CSW_LNK_CLK];
  assign link_strobe = link_sync2[`CSW_LNK_STROBE];
  assign link_crc_ok = link_sync2[`CSW_LNK_CRC_OK];
  assign link_legal = link_sync2[`CSW_LNK_LEGAL];
  assign link_normal = link_sync2[`CSW_LNK_NORMAL];
  assign link_done = link_sync2[`CSW_LNK_DONE];

  // edge finder; resets low like the idle link clock, so no false edge after reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
    end
  end

  // link qualifiers are read at the card clock rising edge only
  assign link_rise = link_clk_s & ~link_clk_d;
  assign link_index = link_sync2[`CSW_LNK_IDX_HI:`CSW_LNK_IDX_LO];
  assign cmd_seen = link_rise & link_strobe;
  assign cmd_crc_bad = cmd_seen & ~link_crc_ok;
  assign cmd_illegal = cmd_seen & link_crc_ok & ~link_legal;
  assign cmd_taken = cmd_seen & link_crc_ok & link_legal;

  // clear-on-read flags in their own bank
  csw_flag_if flags ();

  csw_flag_bank u_flag_bank (
    .i_clk (I_CORE_CLK),
    .i_rst_b (I_RST_B),
    .f (flags.bank)
  );

  // execution events latch into the bank while commands run
  always_comb begin
    flags.set = `CSW_WORD_RESET;
    flags.set[`CSW_BIT_ARG_BOUNDS] = I_ARGUMENT_BOUNDS_FAULT;
    flags.set[`CSW_BIT_ADDR_ALIGN] = I_ADDR_ALIGN_FAULT;
    flags.set[`CSW_BIT_BLOCK_SIZE] = I_BLOCK_SIZE_FAULT;
    flags.set[`CSW_BIT_WIPE_ORDER] = I_WIPE_ORDER_FAULT;
    flags.set[`CSW_BIT_WIPE_SELECT] = I_WIPE_SELECTION_FAULT;
    flags.set[`CSW_BIT_PROT_WRITE] = I_PROTECTED_WRITE_ATTEMPT;
    flags.set[`CSW_BIT_LOCK_FAIL] = I_LOCK_PASSWORD_FAULT;
    flags.set[`CSW_BIT_ECC_FAIL] = I_ECC_UNCORRECTABLE;
    flags.set[`CSW_BIT_CTRL_FAULT] = I_INTERNAL_CONTROLLER_FAULT;
    flags.set[`CSW_BIT_GENERAL] = I_GENERAL_FAULT;
    flags.set[`CSW_BIT_SPEC_REWRITE] = I_SPEC_DATA_REWRITE_FAULT;
    flags.set[`CSW_BIT_WIPE_SKIP] = I_WIPE_SKIP;
    flags.set[`CSW_BIT_WIPE_ABANDON] = I_WIPE_ABANDONED;
  end

  // previous-command faults: bit 1 crc, bit 0 disallowed
  logic [1:0] prev_cmd_fault;
  logic prev_crc_fault;
  logic prev_illegal_fault;

  // the taken command reports these first, so the clear lands one command late
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prev_crc_fault <= 1'b0;
    end else if (cmd_crc_bad) begin
      prev_crc_fault <= 1'b1;
    end else if (cmd_taken) begin
      prev_crc_fault <= 1'b0;
    end
  end

  // disallowed command, same one-command-late clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prev_illegal_fault <= 1'b0;
    end else if (cmd_illegal) begin
      prev_illegal_fault <= 1'b1;
    end else if (cmd_taken) begin
      prev_illegal_fault <= 1'b0;
    end
  end

  assign prev_cmd_fault = {prev_crc_fault, prev_illegal_fault};

  // response phase
  csw_phase_t phase;
  csw_phase_t next_phase;
  logic snap_take;
  csw_word_t snapshot;

  assign snap_take = cmd_taken & link_normal;
  assign resp_sent = link_rise & link_done & (phase == CSW_PH_HOLD);

  always_comb begin
    next_phase = phase;
    unique case (phase)
      CSW_PH_WAIT: begin
        if (snap_take) begin
          next_phase = CSW_PH_HOLD;
        end
      end
      CSW_PH_HOLD: begin
        // a new command while holding replaces the unsent frame
        if (snap_take) begin
          next_phase = CSW_PH_HOLD;
        end else if (resp_sent) begin
          next_phase = CSW_PH_WAIT;
        end
      end
      default: begin
        next_phase = CSW_PH_WAIT;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      phase <= CSW_PH_WAIT;
    end else begin
      phase <= next_phase;
    end
  end

  // word frozen at reception: held flags of earlier commands and state now
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      snapshot <= `CSW_WORD_RESET;
    end else if (snap_take) begin
      snapshot <= csw_assemble(flags.q, prev_cmd_fault, I_LOCKED_FLAG,
                               I_ECC_BYPASS, I_CARD_STATE);
    end
  end

  // only bits that went out are cleared; a later event on a sent bit survives only if it sets in the clear cycle
  always_comb begin
    flags.clr = `CSW_WORD_RESET;
    if (resp_sent && !snap_take) begin
      flags.clr = csw_read_clear_bits(snapshot);
    end
  end

  // normal response frame latched at reception
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RESP_FRAME <= `CSW_FRAME_RESET;
    end else if (snap_take) begin
      O_RESP_FRAME <= csw_frame(link_index, csw_assemble(flags.q, prev_cmd_fault,
                                I_LOCKED_FLAG, I_ECC_BYPASS, I_CARD_STATE));
    end
  end

  // high while a frame waits for its end to be reported
  assign O_RESP_VALID = (phase == CSW_PH_HOLD);

  // live view of the word for the card's own logic
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CARD_STATUS <= `CSW_WORD_RESET;
    end else begin
      O_CARD_STATUS <= csw_assemble(flags.q, prev_cmd_fault, I_LOCKED_FLAG,
                                    I_ECC_BYPASS, I_CARD_STATE);
    end
  end
endmodule : csw_status_word

// File: tb/csw_checker.sv
// port assertions for the card status word
`timescale 1ns/10ps
module csw_checker (
  input logic I_CORE_CLK,
  input logic I_RST_B,
  input logic I_CMD_STROBE,
  input logic I_CMD_CRC_OK,
  input logic I_CMD_LEGAL,
  input logic I_CMD_NORMAL,
  input logic I_RESP_DONE,
  input logic I_ARGUMENT_BOUNDS_FAULT,
  input logic I_WIPE_ABANDONED,
  input logic I_LOCKED_FLAG,
  input logic I_ECC_BYPASS,
  input logic [47:0] O_RESP_FRAME,
  input logic O_RESP_VALID,
  input logic [31:0] O_CARD_STATUS
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_cmd_good;
    $past(I_CMD_STROBE && I_CMD_CRC_OK && I_CMD_LEGAL && I_CMD_NORMAL, 2);
  endsequence
  sequence s_done_seen;
    $past(I_RESP_DONE, 2);
  endsequence
  a_frame_marks: assert property (O_RESP_VALID |->
    O_RESP_FRAME[47:46] == 2'h0 && O_RESP_FRAME[0])
    else $error("frame start or end bit wrong");
  a_frame_reserved: assert property (O_RESP_VALID |-> O_RESP_FRAME[26:25] == 2'h0)
    else $error("reserved frame bits set");
  a_status_reserved: assert property (
    O_CARD_STATUS[18:17] == 2'h0 && O_CARD_STATUS[8:0] == 9'h000)
    else $error("reserved status bits set");
  a_locked_follow: assert property (O_CARD_STATUS[25] == $past(I_LOCKED_FLAG))
    else $error("locked bit does not follow");
  a_bypass_follow: assert property (O_CARD_STATUS[14] == $past(I_ECC_BYPASS))
    else $error("ecc bypass bit does not follow");
  a_bounds_set: assert property (I_ARGUMENT_BOUNDS_FAULT |-> ##2 O_CARD_STATUS[31])
    else $error("argument bounds bit not set");
  a_abandon_set: assert property (I_WIPE_ABANDONED |-> ##2 O_CARD_STATUS[13])
    else $error("wipe abandon bit not set");
  a_rise_after_cmd: assert property ($rose(O_RESP_VALID) |-> s_cmd_good)
    else $error("response without good command");
  a_drop_after_done: assert property ($fell(O_RESP_VALID) |-> s_done_seen)
    else $error("response dropped before sent");
endmodule : csw_checker

// File: tb/csw_host_model.sv
// host side: link clock and command lines
`timescale 1ns/10ps
module csw_host_model (
  input logic i_clk,
  output logic o_card_clk,
  output logic o_strobe,
  output logic o_crc_ok,
  output logic o_legal,
  output logic o_normal,
  output logic [5:0] o_index,
  output logic o_done
);
  initial begin
    {o_card_clk, o_strobe, o_crc_ok, o_legal, o_normal, o_index, o_done} = 12'h000;
  end
  // one 800 ns link clock, running only inside a frame
  task automatic pulse();
    repeat (4) @(posedge i_clk);
    o_card_clk <= #37 1'b1;
    repeat (4) @(posedge i_clk);
    o_card_clk <= 1'b0;
  endtask : pulse
  // released lines show their inverse
  task automatic send(input logic c, input logic l, input logic n, input logic [5:0] x);
    @(posedge i_clk);
    {o_strobe, o_crc_ok, o_legal, o_normal, o_index} <= {1'b1, c, l, n, x};
    pulse();
    {o_strobe, o_crc_ok, o_legal, o_normal, o_index} <= {1'b0, ~c, ~l, ~n, ~x};
  endtask : send
  task automatic ack();
    @(posedge i_clk);
    o_done <= 1'b1;
    pulse();
    o_done <= 1'b0;
  endtask : ack
endmodule : csw_host_model

// File: tb/csw_status_word_tb_top.sv
// self-checking bench for the card status word
`timescale 1ns/10ps
module csw_status_word_tb_top;
  import csw_pkg::*;
  logic clk, rst_b, cclk, stb, crc, leg, nrm, done, lk, byp, valid;
  logic [5:0] idx, ix;
  logic [12:0] ev;
  logic [47:0] frame;
  logic [31:0] stat, pend;
  csw_card_state_t st;
  int bad_count, n_checks;
  int bitpos [13] = '{31, 30, 29, 28, 27, 26, 24, 21, 20, 19, 16, 15, 13};
  logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hF, 4'hC};
  csw_host_model host_u (.i_clk(clk), .o_card_clk(cclk), .o_strobe(stb), .o_crc_ok(crc),
    .o_legal(leg), .o_normal(nrm), .o_index(idx), .o_done(done));
  csw_status_word dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CARD_CLK(cclk),
    .I_CMD_STROBE(stb), .I_CMD_CRC_OK(crc), .I_CMD_LEGAL(leg), .I_CMD_NORMAL(nrm),
    .I_CMD_INDEX(idx), .I_RESP_DONE(done), .I_ARGUMENT_BOUNDS_FAULT(ev[12]),
    .I_ADDR_ALIGN_FAULT(ev[11]), .I_BLOCK_SIZE_FAULT(ev[10]), .I_WIPE_ORDER_FAULT(ev[9]),
    .I_WIPE_SELECTION_FAULT(ev[8]), .I_PROTECTED_WRITE_ATTEMPT(ev[7]),
    .I_LOCK_PASSWORD_FAULT(ev[6]), .I_ECC_UNCORRECTABLE(ev[5]),
    .I_INTERNAL_CONTROLLER_FAULT(ev[4]), .I_GENERAL_FAULT(ev[3]),
    .I_SPEC_DATA_REWRITE_FAULT(ev[2]), .I_WIPE_SKIP(ev[1]), .I_WIPE_ABANDONED(ev[0]),
    .I_LOCKED_FLAG(lk), .I_ECC_BYPASS(byp), .I_CARD_STATE(st), .O_RESP_FRAME(frame),
    .O_RESP_VALID(valid), .O_CARD_STATUS(stat));
  function automatic logic [31:0] exp_word(input logic [31:0] p, input logic l,
      input logic b, input logic [3:0] s);
    exp_word = p | ({31'h0, l} << 25) | ({31'h0, b} << 14) | ({28'h0, s} << 9);
  endfunction : exp_word
  function automatic logic [47:0] exp_frame(input logic [5:0] x, input logic [31:0] w);
    exp_frame = {2'h0, x, w, 7'h00, 1'h1};
  endfunction : exp_frame
  task automatic check(input string what, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    {rst_b, ev, lk, byp, pend} = '0;
    st = CSW_ST_IDLE;
    void'($urandom(18));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      lk <= 1'($urandom);
      byp <= 1'($urandom);
      st <= csw_card_state_t'(codes[i % 11]);
      ev <= 13'h1000 >> i;
      @(posedge clk);
      ev <= 13'h0000;
      repeat (4) @(posedge clk);
      @(negedge clk);
      pend[bitpos[i]] = 1'b1;
      check("status", {16'h0, exp_word(pend, lk, byp, st)}, {16'h0, stat});
      ix = 6'($urandom);
      host_u.send(1'b1, 1'b1, 1'b1, ix);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("frame", exp_frame(ix, exp_word(pend, lk, byp, st)), frame);
      host_u.ack();
      repeat (2) @(posedge clk);
      @(negedge clk);
      pend = '0;
      check("valid after done", 48'h0, {47'h0, valid});
      check("cleared", {16'h0, exp_word(pend, lk, byp, st)}, {16'h0, stat});
    end
    for (int k = 0; k < 2; k++) begin
      host_u.send(k[0], ~k[0], 1'b1, 6'h11);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("refused", 48'h0, {47'h0, valid});
      pend = 32'h0080_0000 >> k;
      repeat (2) begin
        host_u.send(1'b1, 1'b1, 1'b1, 6'h0D);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("previous", exp_frame(6'h0D, exp_word(pend, lk, byp, st)),
              frame);
        pend = '0;
        host_u.ack();
      end
    end
    host_u.send(1'b0, 1'b1, 1'b1, 6'h11);
    host_u.send(1'b1, 1'b1, 1'b0, 6'h07);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("no frame", 48'h0, {47'h0, valid});
    host_u.send(1'b1, 1'b1, 1'b1, 6'h0D);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("cleared previous", exp_frame(6'h0D, exp_word(32'h0, lk, byp, st)), frame);
    host_u.ack();
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : csw_status_word_tb_top

bind csw_status_word csw_checker chk_u (.I_CORE_CLK, .I_RST_B, .I_CMD_STROBE, .I_CMD_CRC_OK,
  .I_CMD_LEGAL, .I_CMD_NORMAL, .I_RESP_DONE, .I_ARGUMENT_BOUNDS_FAULT, .I_WIPE_ABANDONED,
  .I_LOCKED_FLAG, .I_ECC_BYPASS, .O_RESP_FRAME, .O_RESP_VALID, .O_CARD_STATUS);
